// ### apb_host_model.sv
module apb_host_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Requests from the bench
  input wire logic go,
  input wire logic wr,
  input wire logic [7:0] a,
  input wire logic [31:0] wd,
  output logic done,
  output logic [31:0] rd,
  output logic er,
  // Master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 8'h00;
      pwdata <= 32'h0;
      done <= 1'b0;
      rd <= 32'h0;
      er <= 1'b0;
    end else begin
      done <= 1'b0;
      if (go && !psel) begin
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
      end else if (psel && !penable) begin
        penable <= 1'b1;
      end else if (psel && pready) begin
        // Released lines flip so a stale copy never looks valid
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= ~pwrite;
        paddr <= ~paddr;
        pwdata <= ~pwdata;
        done <= 1'b1;
        rd <= prdata;
        er <= pslverr;
      end
    end
  end
endmodule

// ### fifo_level_detect.sv
module fifo_level_detect #(
  parameter int COUNT_W = 8
) (
  // FIFO view
  input wire logic [COUNT_W-1:0] fifoCount,
  input wire logic fifoFull,
  // Threshold
  input wire logic [COUNT_W-1:0] watermark,
  // Result
  output logic levelReached
);

  // ------------------------------------------------------------
  // Level compare
  // ------------------------------------------------------------
  // Full always counts, even if the watermark is above the depth
  always_comb begin
    levelReached = fifoFull | (fifoCount >= watermark);
  end

endmodule

// ### flag_bank.sv
module flag_bank (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Set, clear and flag view
  flag_bank_if.owner bank
);

  localparam int WIDTH = $bits(bank.flags);

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } bank_state_type;

  bank_state_type r;
  bank_state_type next_r;

  // ------------------------------------------------------------
  // Sticky flags
  // ------------------------------------------------------------
  // A set in the clearing cycle survives, so no event is lost
  always_comb begin
    next_r = r;
    next_r.flags = (r.flags & ~bank.clearBits) | bank.setBits;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign bank.flags = r.flags;

endmodule

// ### flag_bank_if.sv
interface flag_bank_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] setBits;
  logic [WIDTH-1:0] clearBits;
  logic [WIDTH-1:0] flags;

  modport owner (input setBits, input clearBits, output flags);
  modport user (output setBits, output clearBits, input flags);
endinterface

// ### touch_error_event_status_regs.sv
module touch_error_event_status_regs
  import touch_status_pkg::*;
#(
  parameter int FIFO_COUNT_W = 8,
  parameter int CAP_KEYS = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [touch_status_pkg::ADDR_W-1:0] paddr,
  input wire logic [touch_status_pkg::DATA_W-1:0] pwdata,
  output logic [touch_status_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link fault reports, one-cycle pulses
  input wire logic baudDetectFail,
  input wire logic calibrationFail,
  input wire logic frameEndMissing,
  input wire logic parityFault,
  input wire logic lengthValid,
  input wire logic [touch_status_pkg::REG_W-1:0] lengthCount,
  // Touch conditions, levels
  input wire logic resistiveTouched,
  input wire logic dualTouchActive,
  // Touch and gesture events, one-cycle pulses
  input wire logic zoomDetect,
  input wire logic rotateDetect,
  input wire logic slideDetect,
  input wire logic sampleDone,
  input wire logic [CAP_KEYS-1:0] capEvent,
  // Coordinate FIFO view
  input wire logic [FIFO_COUNT_W-1:0] fifoCount,
  input wire logic fifoFull,
  // Configuration and notify outputs
  output logic [touch_status_pkg::REG_W-1:0] sampleRate,
  output logic [CAP_KEYS-1:0] capEnable,
  output logic eventNotifyPin
);

  import touch_status_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    bus_state_type bus;
    logic [DATA_W-1:0] rdata;
    logic err;
    logic [REG_W-1:0] clearMask;
    logic clearFault;
    logic clearEvent;
    logic [REG_W-1:0] sampleRate;
    logic [FIFO_COUNT_W-1:0] watermark;
    logic [CAP_KEYS-1:0] capEnable;
    logic notify;
  } regs_type;

  regs_type r;
  regs_type next_r;

  flag_bank_if #(.WIDTH(REG_W)) faultBank ();
  flag_bank_if #(.WIDTH(EVENT_LATCHED_W)) eventBank ();

  logic fifoLevel;
  logic access;
  logic [REG_W-1:0] faultSet;
  logic [EVENT_LATCHED_W-1:0] eventSet;
  // Decoded request, shared by the answer and the fault flags
  logic addrBad;
  logic roWrite;
  logic rateBad;
  logic [DATA_W-1:0] readValue;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic outOfRange(
    input logic [REG_W-1:0] value,
    input logic [REG_W-1:0] low,
    input logic [REG_W-1:0] high
  );
    outOfRange = (value < low) || (value > high);
  endfunction

  function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
    case (addr)
      FAULT_FLAGS_OFFSET,
      EVENT_FLAGS_OFFSET,
      SAMPLE_RATE_OFFSET,
      WATERMARK_OFFSET,
      CAP_ENABLE_OFFSET: isMapped = 1'b1;
      default: isMapped = 1'b0;
    endcase
  endfunction

  function automatic logic isReadOnly(input logic [ADDR_W-1:0] addr);
    isReadOnly = (addr == FAULT_FLAGS_OFFSET) || (addr == EVENT_FLAGS_OFFSET);
  endfunction

  // ------------------------------------------------------------
  // Flag storage
  // ------------------------------------------------------------
  flag_bank u_fault_bank (
    .clk(clk),
    .rst_n(rst_n),
    .bank(faultBank.owner)
  );

  flag_bank u_event_bank (
    .clk(clk),
    .rst_n(rst_n),
    .bank(eventBank.owner)
  );

  fifo_level_detect #(
    .COUNT_W(FIFO_COUNT_W)
  ) u_fifo_level (
    .fifoCount(fifoCount),
    .fifoFull(fifoFull),
    .watermark(r.watermark),
    .levelReached(fifoLevel)
  );

  assign access = psel & penable;

  // ------------------------------------------------------------
  // Access decode
  // ------------------------------------------------------------
  // Decoded once so the answer and the fault flags cannot disagree
  always_comb begin
    addrBad = !isMapped(paddr) || (paddr[1:0] != 2'b00);
    roWrite = pwrite && isReadOnly(paddr);
    // Priority among the three is set where they are used
    rateBad = pwrite && (paddr == SAMPLE_RATE_OFFSET) &&
        outOfRange(pwdata[REG_W-1:0], SAMPLE_RATE_MIN, SAMPLE_RATE_MAX);
  end

  // ------------------------------------------------------------
  // Read data select
  // ------------------------------------------------------------
  // Unused upper bits read as zero
  always_comb begin
    readValue = '0;
    case (paddr)
      FAULT_FLAGS_OFFSET: begin
        readValue[REG_W-1:0] = faultBank.flags;
      end
      EVENT_FLAGS_OFFSET: begin
        // Live levels sit above the latched bits
        readValue[RESISTIVE_TOUCHED_BIT] = resistiveTouched;
        readValue[DUAL_TOUCH_ACTIVE_BIT] = dualTouchActive;
        readValue[EVENT_LATCHED_W-1:0] = eventBank.flags;
      end
      SAMPLE_RATE_OFFSET: begin
        readValue[REG_W-1:0] = r.sampleRate;
      end
      WATERMARK_OFFSET: begin
        readValue[FIFO_COUNT_W-1:0] = r.watermark;
      end
      CAP_ENABLE_OFFSET: begin
        readValue[CAP_KEYS-1:0] = r.capEnable;
      end
      default: begin
        readValue = '0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Event sources
  // ------------------------------------------------------------
  always_comb begin
    eventSet = '0;
    eventSet[5] = zoomDetect;
    eventSet[4] = rotateDetect;
    eventSet[3] = slideDetect;
    // Held while the level stands, so it re-latches after a read
    eventSet[2] = fifoLevel;
    eventSet[1] = |(capEvent & r.capEnable);
    eventSet[0] = sampleDone;
  end

  // ------------------------------------------------------------
  // Fault sources
  // ------------------------------------------------------------
  always_comb begin
    faultSet = '0;
    faultSet[BAUD_DETECT_FAIL_BIT] = baudDetectFail;
    faultSet[CALIBRATION_FAIL_FLAG_BIT] = calibrationFail;
    faultSet[FRAME_END_MISSING_BIT] = frameEndMissing;
    faultSet[PARITY_FAULT_BIT] = parityFault;
    faultSet[LENGTH_FAULT_BIT] = lengthValid &&
        outOfRange(lengthCount, LENGTH_MIN, LENGTH_MAX);
    // Bus-side faults are raised at the completing edge only
    if (r.bus == BUS_DONE) begin
      if (addrBad) begin
        faultSet[BAD_ADDRESS_FLAG_BIT] = 1'b1;
      end else if (roWrite) begin
        faultSet[READONLY_WRITE_FAULT_BIT] = 1'b1;
      end else if (rateBad) begin
        faultSet[SAMPLING_RANGE_FAULT_BIT] = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Bank hookup
  // ------------------------------------------------------------
  // Only bits the host actually saw are cleared; later arrivals stay
  assign faultBank.setBits = faultSet;
  assign faultBank.clearBits = r.clearFault ? r.clearMask : '0;
  assign eventBank.setBits = eventSet;
  assign eventBank.clearBits = r.clearEvent ?
      r.clearMask[EVENT_LATCHED_W-1:0] : '0;

  // ------------------------------------------------------------
  // Bus sequencing and register effects
  // ------------------------------------------------------------
  // One wait cycle lets read data come straight from flip-flops
  always_comb begin
    next_r = r;
    next_r.clearFault = 1'b0;
    next_r.clearEvent = 1'b0;
    case (r.bus)
      BUS_IDLE: begin
        if (access) begin
          next_r.bus = BUS_DONE;
          next_r.rdata = '0;
          next_r.err = 1'b0;
          if (addrBad) begin
            next_r.err = 1'b1;
          end else if (roWrite) begin
            next_r.err = 1'b1;
          end else if (!pwrite) begin
            // Snapshot now; the clear lands two edges later
            next_r.rdata = readValue;
          end
        end
      end
      BUS_DONE: begin
        next_r.bus = BUS_HOLD;
        // Register writes land on the edge that completes the transfer
        if (!r.err) begin
          if (pwrite) begin
            case (paddr)
              SAMPLE_RATE_OFFSET: begin
                // Out-of-range values are dropped, the old rate stays
                if (!outOfRange(pwdata[REG_W-1:0], SAMPLE_RATE_MIN,
                    SAMPLE_RATE_MAX)) begin
                  next_r.sampleRate = pwdata[REG_W-1:0];
                end
              end
              WATERMARK_OFFSET: begin
                next_r.watermark = pwdata[FIFO_COUNT_W-1:0];
              end
              CAP_ENABLE_OFFSET: begin
                next_r.capEnable = pwdata[CAP_KEYS-1:0];
              end
              default: begin
                next_r.watermark = r.watermark;
              end
            endcase
          end else if (paddr == FAULT_FLAGS_OFFSET) begin
            next_r.clearFault = 1'b1;
            // A bit that fires again after the snapshot waits for the next read
            next_r.clearMask = r.rdata[REG_W-1:0] & ~faultSet;
          end else if (paddr == EVENT_FLAGS_OFFSET) begin
            next_r.clearEvent = 1'b1;
            // Same for latched events; live bits 7 and 6 can be in the mask but never reach the event bank
            next_r.clearMask = r.rdata[REG_W-1:0] & ~REG_W'(eventSet);
            next_r.notify = 1'b1;
          end
        end
      end
      BUS_HOLD: begin
        // Gap cycle keeps a back-to-back setup from reusing old data
        next_r.bus = BUS_IDLE;
      end
      default: begin
        next_r.bus = BUS_IDLE;
      end
    endcase
    // A fresh latched event takes the pin back to pending
    if (|eventSet) begin
      next_r.notify = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r.bus <= BUS_IDLE;
      r.rdata <= '0;
      r.err <= 1'b0;
      r.clearMask <= '0;
      r.clearFault <= 1'b0;
      r.clearEvent <= 1'b0;
      r.sampleRate <= SAMPLE_RATE_RESET;
      r.watermark <= FIFO_COUNT_W'(WATERMARK_RESET);
      r.capEnable <= CAP_KEYS'(CAP_ENABLE_RESET);
      r.notify <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Answer decoded from state alone, no path from the bus inputs
  assign pready = (r.bus == BUS_DONE);
  assign pslverr = (r.bus == BUS_DONE) & r.err;
  assign prdata = r.rdata;
  assign sampleRate = r.sampleRate;
  assign capEnable = r.capEnable;
  assign eventNotifyPin = r.notify;

endmodule

// ### touch_error_event_status_regs_tb_top.sv
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module touch_error_event_status_regs_tb_top import touch_status_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, go, wr, done, er, psel, penable, pwrite, pready, pslverr;
  logic lenValid, touch, dual, notify;
  logic [7:0] a, paddr, lenCount, fc, sampleRate;
  logic [31:0] wd, rd, pwdata, prdata;
  logic [3:0] fp, capEnable;
  logic [5:0] ev;
  int err_total, checks_done;

  apb_host_model u_host (.clk(clk), .rst_n(rst_n), .go(go), .wr(wr), .a(a), .wd(wd),
    .done(done), .rd(rd), .er(er), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata));
  touch_error_event_status_regs u_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .baudDetectFail(fp[3]), .calibrationFail(fp[2]),
    .frameEndMissing(fp[1]), .parityFault(fp[0]), .lengthValid(lenValid),
    .lengthCount(lenCount), .resistiveTouched(touch), .dualTouchActive(dual),
    .zoomDetect(ev[5]), .rotateDetect(ev[4]), .slideDetect(ev[3]), .sampleDone(ev[0]),
    .capEvent({3'b000, ev[1]}), .fifoCount(fc), .fifoFull(ev[2]),
    .sampleRate(sampleRate), .capEnable(capEnable), .eventNotifyPin(notify));

  // ----------------------------------------
  // Bus access and run control
  // ----------------------------------------
  task wrap_up;
    if (err_total == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge clk);
    wr <= w;
    a <= ad;
    wd <= d;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (n = 0; n < 20 && done !== 1'b1; n++) @(negedge clk);
    if (done !== 1'b1) begin
      err_total++;
      wrap_up();
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    `CHK("rate", 8'h64, sampleRate)
    `CHK("capEnable", 4'hf, capEnable)
    `CHK("notify", 1'b1, notify)
    bus(0, EVENT_FLAGS_OFFSET, 0);
    `CHK("event", 32'h0, rd)
  endtask

  task t_faults;
    logic [7:0] cnt [4];
    logic [7:0] e;
    cnt = '{8'h00, 8'h65, 8'h66, 8'h01};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) fp <= 4'h1 << i;
      @(posedge clk) fp <= 4'h0;
      e = (i > 1) ? 8'h01 << (i + 4) : 8'h01 << i;
      bus(0, FAULT_FLAGS_OFFSET, 0);
      `CHK("fault", {24'h0, e}, rd)
      bus(0, FAULT_FLAGS_OFFSET, 0);
      `CHK("fault", 32'h0, rd)
      @(posedge clk) lenValid <= 1'b1;
      lenCount <= cnt[i];
      @(posedge clk) lenValid <= 1'b0;
      e = (cnt[i] == 0 || cnt[i] > 8'd101) ? 8'h08 : 8'h00;
      bus(0, FAULT_FLAGS_OFFSET, 0);
      `CHK("length", {24'h0, e}, rd)
    end
  endtask

  task t_bus_faults;
    logic [7:0] v [4];
    logic [7:0] r;
    logic bad;
    v = '{8'h04, 8'h05, 8'h64, 8'h65};
    r = 8'h64;
    bus(1, FAULT_FLAGS_OFFSET, 32'hff);
    `CHK("err", 1'b1, er)
    bus(1, EVENT_FLAGS_OFFSET, 32'hff);
    `CHK("err", 1'b1, er)
    bus(0, FAULT_FLAGS_OFFSET, 0);
    `CHK("fault", 32'h10, rd)
    bus(0, 8'h14, 0);
    `CHK("err", 1'b1, er)
    bus(0, FAULT_FLAGS_OFFSET, 0);
    `CHK("fault", 32'h04, rd)
    for (int i = 0; i < 4; i++) begin
      bad = v[i] < 8'd5 || v[i] > 8'd100;
      r = bad ? r : v[i];
      bus(1, SAMPLE_RATE_OFFSET, {24'h0, v[i]});
      `CHK("rate", r, sampleRate)
      `CHK("err", 1'b0, er)
      bus(0, FAULT_FLAGS_OFFSET, 0);
      `CHK("fault", {26'h0, bad, 5'h0}, rd)
    end
    bus(0, SAMPLE_RATE_OFFSET, 0);
    `CHK("rate", {24'h0, r}, rd)
    `CHK("err", 1'b0, er)
  endtask

  task t_events;
    for (int k = 0; k < 7; k++) begin
      if (k == 6) begin
        bus(1, CAP_ENABLE_OFFSET, 32'he);
        `CHK("capEnable", 4'he, capEnable)
      end
      @(posedge clk) ev <= (k == 6) ? 6'h02 : 6'h01 << k;
      @(posedge clk) ev <= 6'h00;
      repeat (3) @(negedge clk);
      `CHK("notify", k == 6, notify)
      bus(0, EVENT_FLAGS_OFFSET, 0);
      `CHK("event", (k == 6) ? 32'h0 : 32'h1 << k, rd)
      `CHK("notify", 1'b1, notify)
      bus(0, EVENT_FLAGS_OFFSET, 0);
      `CHK("event", 32'h0, rd)
    end
    bus(1, CAP_ENABLE_OFFSET, 32'hf);
    @(posedge clk) fc <= 8'h01;
    @(posedge clk) fc <= 8'h00;
    bus(0, EVENT_FLAGS_OFFSET, 0);
    `CHK("event", 32'h04, rd)
    bus(1, WATERMARK_OFFSET, 32'h3);
    bus(0, WATERMARK_OFFSET, 0);
    `CHK("mark", 32'h3, rd)
    @(posedge clk) fc <= 8'h02;
    @(posedge clk) fc <= 8'h00;
    bus(0, EVENT_FLAGS_OFFSET, 0);
    `CHK("event", 32'h0, rd)
    @(posedge clk) fc <= 8'h03;
    @(posedge clk) fc <= 8'h00;
    bus(0, EVENT_FLAGS_OFFSET, 0);
    `CHK("event", 32'h04, rd)
    @(posedge clk) touch <= 1'b1;
    dual <= 1'b1;
    bus(0, EVENT_FLAGS_OFFSET, 0);
    bus(0, EVENT_FLAGS_OFFSET, 0);
    `CHK("event", 32'hc0, rd)
    @(posedge clk) touch <= 1'b0;
    dual <= 1'b0;
    bus(0, EVENT_FLAGS_OFFSET, 0);
    `CHK("event", 32'h0, rd)
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    {rst_n, go, wr, lenValid, touch, dual} = '0;
    {a, wd, fp, ev, fc} = '0;
    lenCount = 8'h01;
    err_total = 0;
    checks_done = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    t_reset();
    t_faults();
    t_bus_faults();
    t_events();
    wrap_up();
  end
endmodule

// ### touch_status_pkg.sv
package touch_status_pkg;

  // ------------------------------------------------------------
  // Bus and register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam logic [ADDR_W-1:0] FAULT_FLAGS_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] EVENT_FLAGS_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] SAMPLE_RATE_OFFSET = 8'h08;
  localparam logic [ADDR_W-1:0] WATERMARK_OFFSET = 8'h0c;
  localparam logic [ADDR_W-1:0] CAP_ENABLE_OFFSET = 8'h10;

  // ------------------------------------------------------------
  // Fault register bit positions
  // ------------------------------------------------------------
  localparam int BAUD_DETECT_FAIL_BIT = 7;
  localparam int CALIBRATION_FAIL_FLAG_BIT = 6;
  localparam int SAMPLING_RANGE_FAULT_BIT = 5;
  localparam int READONLY_WRITE_FAULT_BIT = 4;
  localparam int LENGTH_FAULT_BIT = 3;
  localparam int BAD_ADDRESS_FLAG_BIT = 2;
  localparam int FRAME_END_MISSING_BIT = 1;
  localparam int PARITY_FAULT_BIT = 0;

  // ------------------------------------------------------------
  // Event register bit positions
  // ------------------------------------------------------------
  localparam int RESISTIVE_TOUCHED_BIT = 7;
  localparam int DUAL_TOUCH_ACTIVE_BIT = 6;
  localparam int EVENT_LATCHED_W = 6;

  // ------------------------------------------------------------
  // Limits and reset values
  // ------------------------------------------------------------
  localparam logic [REG_W-1:0] SAMPLE_RATE_MIN = 8'h05;
  localparam logic [REG_W-1:0] SAMPLE_RATE_MAX = 8'h64;
  localparam logic [REG_W-1:0] LENGTH_MIN = 8'h01;
  localparam logic [REG_W-1:0] LENGTH_MAX = 8'h65;
  localparam logic [REG_W-1:0] SAMPLE_RATE_RESET = 8'h64;
  localparam logic [REG_W-1:0] WATERMARK_RESET = 8'h01;
  localparam logic [3:0] CAP_ENABLE_RESET = 4'hf;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_DONE = 3'b010,
    BUS_HOLD = 3'b100
  } bus_state_type;

endpackage

// ### touch_status_sva.sv
module touch_status_sva
  import touch_status_pkg::*;
#(
  parameter int CAP_KEYS = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [touch_status_pkg::ADDR_W-1:0] paddr,
  input wire logic [touch_status_pkg::DATA_W-1:0] pwdata,
  input wire logic [touch_status_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Events and outputs
  input wire logic zoomDetect,
  input wire logic rotateDetect,
  input wire logic slideDetect,
  input wire logic sampleDone,
  input wire logic [CAP_KEYS-1:0] capEvent,
  input wire logic [touch_status_pkg::REG_W-1:0] sampleRate,
  input wire logic [CAP_KEYS-1:0] capEnable,
  input wire logic eventNotifyPin
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic done;
  logic wrDone;
  logic mapped;
  logic rateBad;
  logic newEvent;
  assign done = psel && penable && pready;
  assign wrDone = done && pwrite;
  assign mapped = paddr inside {FAULT_FLAGS_OFFSET, EVENT_FLAGS_OFFSET, SAMPLE_RATE_OFFSET,
                                WATERMARK_OFFSET, CAP_ENABLE_OFFSET};
  assign rateBad = pwdata[7:0] < SAMPLE_RATE_MIN || pwdata[7:0] > SAMPLE_RATE_MAX;
  assign newEvent = zoomDetect || rotateDetect || slideDetect || sampleDone
                    || |(capEvent & capEnable);

  property p_ro_write;
    wrDone && (paddr == FAULT_FLAGS_OFFSET || paddr == EVENT_FLAGS_OFFSET) |-> pslverr;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("status write not refused");
  property p_one_wait;
    psel && $rose(penable) |-> !pready ##1 pready ##1 !pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("answer timing off");
  property p_unmapped;
    done && !mapped |-> pslverr && prdata == '0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("bad address accepted");
  property p_rate_bad;
    wrDone && paddr == SAMPLE_RATE_OFFSET && rateBad |=> $stable(sampleRate);
  endproperty
  a_rate_bad: assert property (p_rate_bad) else $error("bad rate stored");
  property p_rate_ok;
    wrDone && paddr == SAMPLE_RATE_OFFSET && !rateBad |=> sampleRate == $past(pwdata[7:0]);
  endproperty
  a_rate_ok: assert property (p_rate_ok) else $error("good rate not stored");
  property p_cap_en;
    wrDone && paddr == CAP_ENABLE_OFFSET |=> capEnable == $past(pwdata[CAP_KEYS-1:0]);
  endproperty
  a_cap_en: assert property (p_cap_en) else $error("enable not stored");
  property p_notify_read;
    done && !pwrite && paddr == EVENT_FLAGS_OFFSET && !newEvent && !$past(newEvent)
      |=> eventNotifyPin;
  endproperty
  a_notify_read: assert property (p_notify_read) else $error("notify not set");
  property p_notify_event;
    newEvent |-> ##[1:2] !eventNotifyPin;
  endproperty
  a_notify_event: assert property (p_notify_event) else $error("event missed");
endmodule

bind touch_error_event_status_regs touch_status_sva #(.CAP_KEYS(CAP_KEYS)) u_sva (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .zoomDetect(zoomDetect), .rotateDetect(rotateDetect), .slideDetect(slideDetect),
  .sampleDone(sampleDone), .capEvent(capEvent), .sampleRate(sampleRate),
  .capEnable(capEnable), .eventNotifyPin(eventNotifyPin));
